// file: wwdt_top.sv
// wwdt_top.sv: windowed watchdog with prescaled 7-bit down-counter and reset request
// assumes option pins are static and power events come from core-clock logic
//
// What this block does
// - decrement counter every 16384 oscillator clocks
// - armed, 40h to 3Fh starts reset pulse
// - counter keeps running even when not armed
// - disarmed after reset; disarm attempts ignored
// - write arm set, top clear: immediate reset
// - six low bits set 64 timeout steps
// - control writes never clear the prescaler
// - halt, interrupt enable 0, option 1: reset
// - halt, both 0: one decrement, then stop
// - interrupt resumes after 256/4096 clocks; reset disarms
// - enable 1: active halt freezes; wake rules
// - hardware option keeps watchdog always armed
// - control register resets to 7Fh
// - arm bit cleared only by reset
`timescale 1ns/100ps
`include "wwdt_consts.svh"
module wwdt_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire wwdt_pkg::wwdt_bus_s i_bus,
  output logic [7:0] o_rdata,
  // option and power control
  input wire logic i_hw_watchdog,
  input wire logic i_halt_reset_option,
  input wire logic i_clock_interrupt_enable,
  input wire wwdt_pkg::wwdt_pwr_s i_pwr,
  // status
  output logic o_reset_req,
  output logic o_halted,
  output logic [7:0] o_ctrl
);
  import wwdt_pkg::*;

  // behaviour a user of this block must know:
  // - the prescaler phase is invisible to software and a control write
  //   leaves it alone, so the first decrement after a refresh lands
  //   anywhere up to one full prescaler period later
  // - the arm bit only ever sets; nothing but i_reset clears it
  // - with the hardware option, any control write with the top count
  //   bit clear fires a reset, whatever the written arm bit
  // - halt with the interrupt enable low and the halt-reset option high
  //   fires a reset from any state, armed or not
  // - o_reset_req is a request only; the system must answer it with
  //   i_reset, the block keeps running until then
  // - after i_reset, and after a wake from the stop state, the count
  //   holds for the wake wait before it resumes
  // - o_rdata shows zero except in the cycle after a control read
  // - the count may be written with any value; top bit clear with the
  //   arm bit set resets at once
  // - slow and wait modes are not seen here and change nothing

  localparam int unsigned RST_CYC = (`WWDT_RST_PULSE_CYC < 1) ? 1 : `WWDT_RST_PULSE_CYC;

  logic arm_bit_ff;
  logic [6:0] cnt_ff;
  logic [`WWDT_PRESC_W-1:0] presc_ff;
  wwdt_state_e state_ff;
  logic [`WWDT_WAKE_W-1:0] wake_ff;
  logic dec_once_ff;
  logic [7:0] pulse_ff;
  logic [7:0] rdata_ff;
  logic reset_req_ff;
  logic halted_ff;
  logic hw_ff;

  wire ctrl_sel = i_bus.addr == `WWDT_CTRL_OFS;
  wire ctrl_wr = i_bus.wr && ctrl_sel;
  wire ctrl_rd = i_bus.rd && ctrl_sel;
  // hardware option overrides the software arm bit
  wire armed = arm_bit_ff || hw_ff;
  wire presc_tick = presc_ff == `WWDT_PRESC_W'(`WWDT_PRESC_CYCLES - 1);
  // counter runs in run state; slow and wait are not distinguished
  wire counting = (state_ff == WWDT_RUN) || ((state_ff == WWDT_HALT_STOP) && dec_once_ff);
  wire dec = counting && presc_tick;
  wire [6:0] cnt_dec = cnt_ff - 7'h01;
  wire wr_arm = i_bus.wdata[`WWDT_ARM_BIT];
  wire [6:0] nxt_cnt = ctrl_wr ? i_bus.wdata[6:0] : (dec ? cnt_dec : cnt_ff);
  wire nxt_arm = arm_bit_ff | (ctrl_wr & wr_arm);
  wire expire = armed && dec && (cnt_ff == 7'h40);
  wire sw_reset = ctrl_wr && (wr_arm || hw_ff) && !i_bus.wdata[`WWDT_TOP_BIT];
  wire halt_reset = i_pwr.halt_enter && !i_clock_interrupt_enable
    && i_halt_reset_option;
  wire fire = expire || sw_reset || halt_reset;
  wire wake_done = wake_ff == '0;
  wire [`WWDT_WAKE_W-1:0] wake_len = i_pwr.long_wake ?
    `WWDT_WAKE_W'(`WWDT_WAKE_LONG - 1) : `WWDT_WAKE_W'(`WWDT_WAKE_SHORT - 1);

  assign o_rdata = rdata_ff;
  assign o_reset_req = reset_req_ff;
  assign o_halted = halted_ff;
  assign o_ctrl = {arm_bit_ff, cnt_ff};

  // hardware option pin: three-stage synchroniser; a level counts
  // once the second and third stages agree
  logic [2:0] hw_sync_ff;
  wire hw_agree = hw_sync_ff[1] == hw_sync_ff[2];

  always_ff @(posedge i_core_clk)
  begin
    hw_sync_ff <= {hw_sync_ff[1:0], i_hw_watchdog};
  end

  // option level held while the stages disagree
  always_ff @(posedge i_core_clk)
  begin
    if (hw_agree)
      hw_ff <= hw_sync_ff[2];
  end

  // prescaler free-runs and is never cleared by a write
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      presc_ff <= '0;
    else
      presc_ff <= presc_ff + `WWDT_PRESC_W'(1);
  end

  // arm bit: set by software, cleared only by reset
  // a written zero is simply or-ed away
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      arm_bit_ff <= 1'b0;
    else
      arm_bit_ff <= nxt_arm;
  end

  // count: loaded by a control write, else stepped by the prescaler
  // a write wins over a decrement in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      cnt_ff <= 7'h7F;
    else
      cnt_ff <= nxt_cnt;
  end

  // halt entry and wake decode; the interrupt enable picks active halt,
  // otherwise the halt-reset option picks between reset and stop
  wire halt_to_active = i_pwr.halt_enter && i_clock_interrupt_enable;
  wire halt_to_stop = i_pwr.halt_enter && !i_clock_interrupt_enable
    && !i_halt_reset_option;
  wire act_wake = i_pwr.ext_irq || i_pwr.osc_irq;
  wire stop_wake = i_pwr.ext_irq;

  // next values of the halt machine
  wwdt_state_e nxt_state;
  logic [`WWDT_WAKE_W-1:0] nxt_wake;
  logic nxt_dec_once;

  // halt handling: the stop state lets exactly one more decrement
  // through, then freezes the count until an external interrupt
  always_comb
  begin
    nxt_state = state_ff;
    nxt_wake = wake_ff;
    nxt_dec_once = dec_once_ff;
    case (state_ff)
      WWDT_RUN:
      begin
        if (halt_to_active)
          nxt_state = WWDT_ACT_HALT;
        else if (halt_to_stop)
        begin
          nxt_state = WWDT_HALT_STOP;
          nxt_dec_once = 1'b1;
        end
      end

      // only an external interrupt leaves the stop state
      WWDT_HALT_STOP:
      begin
        if (dec)
          nxt_dec_once = 1'b0;
        if (stop_wake)
        begin
          nxt_state = WWDT_WAKE_WAIT;
          nxt_wake = wake_len;
          nxt_dec_once = 1'b0;
        end
      end

      // oscillator or external interrupt resumes counting at once
      WWDT_ACT_HALT:
      begin
        if (act_wake)
          nxt_state = WWDT_RUN;
      end

      // count the wake wait down to zero, then resume
      WWDT_WAKE_WAIT:
      begin
        if (wake_done)
          nxt_state = WWDT_RUN;
        else
          nxt_wake = wake_ff - `WWDT_WAKE_W'(1);
      end

      // unused code: fall back to run
      default:
      begin
        nxt_state = WWDT_RUN;
      end
    endcase
  end

  // state register; reset enters the short wake wait, so counting
  // resumes 256 clocks after release
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      state_ff <= WWDT_WAKE_WAIT;
    else
      state_ff <= nxt_state;
  end

  // wake counter
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      wake_ff <= `WWDT_WAKE_W'(`WWDT_WAKE_SHORT - 1);
    else
      wake_ff <= nxt_wake;
  end

  // single decrement allowed in the stop state
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      dec_once_ff <= 1'b0;
    else
      dec_once_ff <= nxt_dec_once;
  end

  // reset pulse stretcher: a new fire restarts the full length,
  // so the request stands for the whole pulse after the last fire
  logic [7:0] nxt_pulse;
  logic nxt_req;
  wire pulse_run = pulse_ff != 8'h00;

  always_comb
  begin
    nxt_pulse = pulse_ff;
    nxt_req = reset_req_ff;
    if (fire)
    begin
      nxt_pulse = 8'(RST_CYC - 1);
      nxt_req = 1'b1;
    end
    else if (pulse_run)
      nxt_pulse = pulse_ff - 8'h01;
    else
      nxt_req = 1'b0;
  end

  // pulse length counter
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      pulse_ff <= 8'h00;
    else
      pulse_ff <= nxt_pulse;
  end

  // reset request level, straight from this flop
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      reset_req_ff <= 1'b0;
    else
      reset_req_ff <= nxt_req;
  end

  // read data stand for one cycle after the strobe, zero otherwise;
  // other addresses read as zero
  wire [7:0] rd_word = ctrl_rd ? {arm_bit_ff, cnt_ff} : 8'h00;
  wire in_halt = (state_ff == WWDT_HALT_STOP) || (state_ff == WWDT_ACT_HALT);

  // read data register
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= rd_word;
  end

  // status: set in either halt state; the count freezes in active halt, after one more decrement in stop
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      halted_ff <= 1'b0;
    else
      halted_ff <= in_halt;
  end
endmodule : wwdt_top

// file: wwdt_consts.svh
// wwdt_consts.svh: offsets, reset values and timing counts of the windowed watchdog
// assumes inclusion by the watchdog package and module only
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH
`define WWDT_ADDR_W 8
`define WWDT_CTRL_OFS 8'h24
`define WWDT_CTRL_RST 8'h7F
`define WWDT_ARM_BIT 7
`define WWDT_TOP_BIT 6
`define WWDT_PRESC_CYCLES 16384
`define WWDT_PRESC_W 14
`define WWDT_CLK_PERIOD_PS 4000
`define WWDT_RST_PULSE_PS 500000
`define WWDT_RST_PULSE_CYC ((`WWDT_RST_PULSE_PS) / (`WWDT_CLK_PERIOD_PS))
`define WWDT_WAKE_SHORT 256
`define WWDT_WAKE_LONG 4096
`define WWDT_WAKE_W 13
`endif

// file: wwdt_pkg.sv
// wwdt_pkg.sv: types of the windowed watchdog
// assumes wwdt_consts.svh is on the include path
`include "wwdt_consts.svh"
package wwdt_pkg;
  typedef struct packed {
    logic [`WWDT_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wwdt_bus_s;
  typedef struct packed {
    logic halt_enter;
    logic ext_irq;
    logic osc_irq;
    logic long_wake;
  } wwdt_pwr_s;
  typedef enum logic [1:0] {
    WWDT_RUN = 2'b00,
    WWDT_HALT_STOP = 2'b01,
    WWDT_ACT_HALT = 2'b10,
    WWDT_WAKE_WAIT = 2'b11
  } wwdt_state_e;
endpackage : wwdt_pkg

// file: wwdt_top_props.sv
// wwdt_top_props.sv: port assertions of wwdt_top
// assumes it is bound onto wwdt_top
`timescale 1ns/100ps
module wwdt_props (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire wwdt_pkg::wwdt_bus_s i_bus,
  input wire logic i_halt_reset_option,
  input wire logic i_clock_interrupt_enable,
  input wire wwdt_pkg::wwdt_pwr_s i_pwr,
  input wire logic o_reset_req,
  input wire logic o_halted,
  input wire logic [7:0] o_ctrl
);
  import wwdt_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire wr_c = i_bus.wr && i_bus.addr == 8'h24;
  wire hlt = i_pwr.halt_enter;
  wire ien = i_clock_interrupt_enable;
  wire [6:0] cnt = o_ctrl[6:0];
  sequence at40_s; o_ctrl[7] && !wr_c && cnt == 7'h40; endsequence
  sequence to3f_s; cnt == 7'h3F; endsequence
  arm_hold_a: assert property (o_ctrl[7] |=> o_ctrl[7])
    else $error("arm bit dropped");
  wr_load_a: assert property (wr_c |=> cnt == $past(i_bus.wdata[6:0]))
    else $error("count not loaded");
  sw_rst_a: assert property (wr_c && i_bus.wdata[7:6] == 2'b10 |=> o_reset_req)
    else $error("no software reset");
  pulse_len_a: assert property ($rose(o_reset_req) |-> ##124 o_reset_req ##1 !o_reset_req)
    else $error("bad pulse length");
  step_one_a: assert property (!wr_c |=> cnt == $past(cnt) || cnt == $past(cnt) - 7'h1)
    else $error("count jumped");
  expire_a: assert property (at40_s ##1 to3f_s |-> o_reset_req)
    else $error("no expiry reset");
  halt_rst_a: assert property (hlt && o_ctrl[7] && !ien && i_halt_reset_option
    |-> ##[1:2] o_reset_req) else $error("halt did not reset");
  act_halt_a: assert property (hlt && ien |-> ##[1:2] o_halted)
    else $error("no active halt");
endmodule : wwdt_props
bind wwdt_top wwdt_props i_wwdt_props (.*);

// file: wwdt_top_tb.sv
// wwdt_top_tb.sv: self-checking bench of wwdt_top
// assumes wwdt_pkg and the checker compile first
`timescale 1ns/100ps
module wwdt_top_tb;
  import wwdt_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic ien = 0;
  logic hopt = 0;
  logic hw = 0;
  wwdt_bus_s bus = '0;
  wwdt_pwr_s pwr = '0;
  logic [7:0] rd, ctrl;
  logic req, hd;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  always #2 clk = ~clk;
  wwdt_top i_wwdt_top (.i_core_clk(clk), .i_reset(rst), .i_bus(bus), .o_rdata(rd),
    .i_hw_watchdog(hw), .i_halt_reset_option(hopt), .i_clock_interrupt_enable(ien),
    .i_pwr(pwr), .o_reset_req(req), .o_halted(hd), .o_ctrl(ctrl));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic go(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    bus <= {a, d, w, !w};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : go
  // pulse a power event, then wait up to k cycles for a reset request
  task automatic ev(input logic [3:0] p, input int k);
    @(posedge clk);
    pwr <= p;
    @(posedge clk);
    pwr <= '0;
    #1;
    n = 0;
    while (req !== 1'b1 && n < k)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : ev
  task automatic do_rst;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask : do_rst
  task automatic t_reg;
    chk("ctrl", 8'h7F, ctrl);
    go(8'h24, 8'hC5, 1);
    chk("ctrl", 8'hC5, ctrl);
    go(8'h24, 8'h7F, 1);
    go(8'h24, 8'h00, 0);
    chk("rdata", 8'hFF, rd);
    go(8'h31, 8'h00, 0);
    chk("unmapped", 8'h00, rd);
    $display("done registers");
  endtask : t_reg
  task automatic t_expire;
    go(8'h24, 8'hC0, 1);
    ev(4'h0, 17000);
    chk("count", 8'hBF, ctrl);
    n = 0;
    while (req === 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("pulse", 8'd125, n[7:0]);
    do_rst;
    go(8'h24, 8'h80, 1);
    chk("swreset", 8'h01, {7'h0, req});
    @(posedge clk);
    hw <= 1'b1;
    do_rst;
    go(8'h24, 8'h00, 1);
    chk("hwreset", 8'h01, {7'h0, req});
    @(posedge clk);
    hw <= 1'b0;
    do_rst;
    $display("done expiry");
  endtask : t_expire
  task automatic t_halt;
    repeat (300) @(posedge clk);
    ien <= 1'b1;
    ev(4'b1000, 3);
    chk("halted", 8'h01, {7'h0, hd});
    ev(4'b0010, 3);
    chk("woken", 8'h00, {7'h0, hd});
    @(posedge clk);
    ien <= 1'b0;
    ev(4'b1000, 3);
    chk("stopped", 8'h01, {7'h0, hd});
    ev(4'b0100, 3);
    chk("restarted", 8'h00, {7'h0, hd});
    @(posedge clk);
    hopt <= 1'b1;
    go(8'h24, 8'hC5, 1);
    ev(4'b1000, 3);
    chk("haltreset", 8'h01, {7'h0, req});
    $display("done halt");
  endtask : t_halt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      print_verdict;
    end
  end
  initial
  begin
    do_rst;
    t_reg;
    t_expire;
    t_halt;
    print_verdict;
  end
endmodule : wwdt_top_tb
